/* File: rtl/dirb_ctrl.sv */
// interrupt pins, reset and mode sampling, and parallel bus strobes
// Functional notes
// - falling edge on interrupt pin raises request
// - nmi taken whatever the global mask
// - shared select pin sampled during reset
// - high selects internal, low external memory
// - write strobe low exactly while driving bus
// - read strobe low while accepting bus data
// - reset holds program counter at zero
// - data bus released except during writes
module dirb_ctrl
    import dirb_pkg::*;
#(
    parameter int DATA_W = DIRB_DATA_W,
    parameter int PC_W = DIRB_PC_W,
    parameter int STROBE_CYCLES = DIRB_STROBE_CYCLES
) (
    // clock and logic reset
    input wire logic clk,
    input wire logic rst_n,
    // device pins (asynchronous)
    input wire logic chip_reset_n,
    input wire logic ext_irq_n,
    input wire logic nmi_sel_n,
    // parallel data bus, split into in, out and enable
    input wire logic [DATA_W-1:0] bus_data_in,
    output logic [DATA_W-1:0] bus_data_out,
    output logic bus_data_oe,
    output logic write_strobe_n,
    output logic read_strobe_n,
    // core side: status word mask and interrupt handshake
    input wire logic global_irq_mask,
    input wire logic ext_irq_ack,
    input wire logic nmi_ack,
    output logic ext_irq_take,
    output logic nmi_take,
    // core side: bus requests
    input wire logic wr_req,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_req,
    output logic bus_busy,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid,
    // core side: program counter and mode
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_load_value,
    output logic [PC_W-1:0] program_counter,
    output logic program_memory_select,
    output logic in_reset
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic rs_s1_reg, rs_s2_reg;
    logic int_s1_reg, int_s2_reg, int_s3_reg;
    logic nmi_s1_reg, nmi_s2_reg, nmi_s3_reg;
    logic [DATA_W-1:0] d_s1_reg, d_s2_reg;
    logic int_fall, nmi_fall;

    // two flops per pin; the interrupt pins add a third flop so the second and third feed the edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_s1_reg <= 1'b0;
            rs_s2_reg <= 1'b0;
            int_s1_reg <= 1'b1;
            int_s2_reg <= 1'b1;
            int_s3_reg <= 1'b1;
            nmi_s1_reg <= 1'b1;
            nmi_s2_reg <= 1'b1;
            nmi_s3_reg <= 1'b1;
            d_s1_reg <= '0;
            d_s2_reg <= '0;
        end else begin
            rs_s1_reg <= chip_reset_n;
            rs_s2_reg <= rs_s1_reg;
            int_s1_reg <= ext_irq_n;
            int_s2_reg <= int_s1_reg;
            int_s3_reg <= int_s2_reg;
            nmi_s1_reg <= nmi_sel_n;
            nmi_s2_reg <= nmi_s1_reg;
            nmi_s3_reg <= nmi_s2_reg;
            d_s1_reg <= bus_data_in;
            d_s2_reg <= d_s1_reg;
        end
    end

    // edges only; a level held low never repeats a request
    assign int_fall = int_s3_reg & ~int_s2_reg;
    assign nmi_fall = nmi_s3_reg & ~nmi_s2_reg;

    // ************************************************************
    // reset state and mode sampling
    // ************************************************************
    // in_reset follows the synchronised pin, so it lags by three cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_reset <= 1'b1;
        end else begin
            in_reset <= ~rs_s2_reg;
        end
    end

    // the pin is a mode strap while reset is low, last value kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_memory_select <= DIRB_SEL_RESET;
        end else if (!rs_s2_reg) begin
            program_memory_select <= nmi_s2_reg;
        end
    end

    // ************************************************************
    // program counter
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_counter <= DIRB_PC_RESET;
        end else if (!rs_s2_reg) begin
            program_counter <= DIRB_PC_RESET;
        end else if (pc_load) begin
            program_counter <= pc_load_value;
        end else if (pc_step) begin
            program_counter <= program_counter + 1'b1;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    logic ext_pend_reg;

    // set wins over acknowledge; reset time drops pending events
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_pend_reg <= 1'b0;
            nmi_take <= 1'b0;
        end else if (!rs_s2_reg) begin
            ext_pend_reg <= 1'b0;
            nmi_take <= 1'b0;
        end else begin
            ext_pend_reg <= int_fall | (ext_pend_reg & ~ext_irq_ack);
            nmi_take <= nmi_fall | (nmi_take & ~nmi_ack);
        end
    end

    // mask gates the maskable source only; pending survives while masked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_irq_take <= 1'b0;
        end else begin
            ext_irq_take <= ext_pend_reg & ~global_irq_mask & ~ext_irq_ack & rs_s2_reg;
        end
    end

    // ************************************************************
    // bus sequencer
    // ************************************************************
    dirb_state_e state_reg;
    logic [2:0] cnt_reg;
    logic idle_ok;

    assign idle_ok = (state_reg == DIRB_IDLE) && rs_s2_reg;

    // write wins over read when both are requested together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= DIRB_IDLE;
            cnt_reg <= DIRB_CNT_ZERO;
        end else if (!rs_s2_reg) begin
            state_reg <= DIRB_IDLE;
            cnt_reg <= DIRB_CNT_ZERO;
        end else begin
            case (state_reg)
                DIRB_IDLE: begin
                    // loaded with the full length so the strobe stays low STROBE_CYCLES
                    cnt_reg <= 3'(STROBE_CYCLES);
                    if (wr_req) begin
                        state_reg <= DIRB_WRITE;
                    end else if (rd_req) begin
                        state_reg <= DIRB_READ;
                    end
                end
                DIRB_WRITE, DIRB_READ: begin
                    cnt_reg <= cnt_reg - 1'b1;
                    if (cnt_reg == DIRB_CNT_ONE) begin
                        state_reg <= DIRB_IDLE;
                    end
                end
                default: begin
                    state_reg <= DIRB_IDLE;
                end
            endcase
        end
    end

    // strobes and enable from one flop set; oe and write strobe never part
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_strobe_n <= 1'b1;
            bus_data_oe <= 1'b0;
            read_strobe_n <= 1'b1;
            bus_busy <= 1'b0;
        end else begin
            if (idle_ok && wr_req) begin
                write_strobe_n <= 1'b0;
                bus_data_oe <= 1'b1;
            end else if (!rs_s2_reg || (state_reg == DIRB_WRITE && cnt_reg == DIRB_CNT_ONE)) begin
                write_strobe_n <= 1'b1;
                bus_data_oe <= 1'b0;
            end
            if (idle_ok && !wr_req && rd_req) begin
                read_strobe_n <= 1'b0;
            end else if (!rs_s2_reg || (state_reg == DIRB_READ && cnt_reg == DIRB_CNT_ONE)) begin
                read_strobe_n <= 1'b1;
            end
            bus_busy <= idle_ok ? (wr_req | rd_req) :
                (rs_s2_reg && !(state_reg != DIRB_IDLE && cnt_reg == DIRB_CNT_ONE));
        end
    end

    // data captured on the last strobe cycle; synchroniser lag means
    // the sample was taken two cycles earlier, still under the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_out <= '0;
            rd_data <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (idle_ok && wr_req) begin
                bus_data_out <= wr_data;
            end
            if (rs_s2_reg && state_reg == DIRB_READ && cnt_reg == DIRB_CNT_ONE) begin
                rd_data <= d_s2_reg;
                rd_valid <= 1'b1;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_INT_EDGE: assert property (int_fall && rs_s2_reg |=> ext_pend_reg)
        else $error("interrupt edge not recorded");
    AST_INT_LEVEL: assert property ($rose(ext_pend_reg) |-> $past(int_fall))
        else $error("interrupt request without an edge");
    AST_NMI_MASK: assert property (nmi_fall && rs_s2_reg && global_irq_mask |=> nmi_take)
        else $error("nmi blocked by mask");
    AST_SEL_SAMPLE: assert property (!rs_s2_reg |=> program_memory_select == $past(nmi_s2_reg))
        else $error("select not sampled in reset");
    AST_SEL_HOLD: assert property (rs_s2_reg && $past(rs_s2_reg) |-> $stable(program_memory_select))
        else $error("select changed outside reset");
    AST_WR_OE: assert property (write_strobe_n == !bus_data_oe)
        else $error("write strobe and data enable differ");
    // a chip reset may cut a strobe short, so it stops the length check
    AST_WR_LEN: assert property (disable iff (!rst_n || !rs_s2_reg)
        $fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
        else $error("write strobe length wrong");
    AST_RD_LEN: assert property (disable iff (!rst_n || !rs_s2_reg)
        $fell(read_strobe_n) |-> !read_strobe_n [*4] ##1 read_strobe_n)
        else $error("read strobe length wrong");
    AST_RD_VALID: assert property (rd_valid |-> !$past(read_strobe_n))
        else $error("read data taken outside strobe");
    AST_PC_ZERO: assert property (!rs_s2_reg |=> program_counter == DIRB_PC_RESET)
        else $error("program counter not zero in reset");
    AST_EXCL: assert property (!(bus_data_oe && !read_strobe_n))
        else $error("drive during read strobe");

    COV_WRITE: cover property ($fell(write_strobe_n) ##4 $rose(write_strobe_n));
    COV_READ: cover property ($fell(read_strobe_n) ##4 rd_valid);
    COV_NMI_MASKED: cover property (global_irq_mask && $rose(nmi_take));
    COV_EXT_SEL: cover property (in_reset && !program_memory_select ##1 !in_reset);
endmodule // dirb_ctrl

/* File: rtl/dirb_pkg.sv */
// shared constants for the interrupt, reset and bus strobe block
package dirb_pkg;
    // ************************************************************
    // widths and reset values
    // ************************************************************
    localparam int DIRB_DATA_W = 16;
    localparam int DIRB_PC_W = 12;
    localparam logic [DIRB_PC_W-1:0] DIRB_PC_RESET = 12'h000;
    localparam logic DIRB_SEL_RESET = 1'b1; // internal memory until sampled
    // ************************************************************
    // timing: strobe length in cycles at 50 MHz
    // ************************************************************
    localparam int DIRB_STROBE_CYCLES = 4;
    localparam logic [2:0] DIRB_CNT_ZERO = 3'h0;
    localparam logic [2:0] DIRB_CNT_ONE = 3'h1;
    // bus sequencer states
    typedef enum logic [1:0] {DIRB_IDLE, DIRB_WRITE, DIRB_READ} dirb_state_e;
endpackage

/* File: verif/dirb_mem_model.sv */
// external memory model on the far side of the parallel data bus
module dirb_mem_model (
    // clock
    input wire logic clk,
    // device strobes and write data
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [15:0] bus_data_out,
    // answer speed and the word seen on the bus from this side
    input wire logic slow,
    output logic [15:0] mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem_reg = 16'h0000;
    logic [15:0] float_reg = 16'h5a5a;
    logic late_reg = 1'b0;
    // store the latest written word; a released bus never keeps a value
    always @(posedge clk) begin
        if (!write_strobe_n) mem_reg <= bus_data_out;
        float_reg <= ~float_reg;
    end
    // a slow part answers half a cycle after the read strobe falls
    always @(negedge clk) late_reg <= !read_strobe_n;
    assign mem_data = (!read_strobe_n && (!slow || late_reg)) ? mem_reg : float_reg;
endmodule // dirb_mem_model

/* File: verif/test_dsp_interrupt_reset_bus_strobes.sv */
// self-checking bench for the interrupt, reset and bus strobe block
module test_dsp_interrupt_reset_bus_strobes;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, chip_reset_n = 0, ext_irq_n = 1, nmi_sel_n = 0, slow = 0;
    logic global_irq_mask = 0, ext_irq_ack = 0, nmi_ack = 0, wr_req = 0, rd_req = 0;
    logic pc_step = 0, pc_load = 0, bus_data_oe, write_strobe_n, read_strobe_n;
    logic ext_irq_take, nmi_take, bus_busy, rd_valid, program_memory_select, in_reset;
    logic [15:0] wr_data = 16'h0000, bus_data_out, rd_data, mem_data, bus_data_in, d;
    logic [11:0] pc_load_value = 12'h000, program_counter, v;
    int bad_count = 0, tests_run = 0, seed = 59025, n;
    always #10 clk = ~clk;
    // the device wins the wire only while it drives it
    assign bus_data_in = bus_data_oe ? bus_data_out : mem_data;
    dirb_ctrl dut (.clk(clk), .rst_n(rst_n), .chip_reset_n(chip_reset_n),
        .ext_irq_n(ext_irq_n), .nmi_sel_n(nmi_sel_n), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .global_irq_mask(global_irq_mask), .ext_irq_ack(ext_irq_ack), .nmi_ack(nmi_ack),
        .ext_irq_take(ext_irq_take), .nmi_take(nmi_take), .wr_req(wr_req),
        .wr_data(wr_data), .rd_req(rd_req), .bus_busy(bus_busy), .rd_data(rd_data),
        .rd_valid(rd_valid), .pc_step(pc_step), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .program_counter(program_counter),
        .program_memory_select(program_memory_select), .in_reset(in_reset));
    dirb_mem_model partner (.clk(clk), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .bus_data_out(bus_data_out), .slow(slow),
        .mem_data(mem_data));
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input bit ok, input string what);
        tests_run++;
        if (!ok) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    function automatic logic [11:0] exp_pc(input logic [11:0] base, input int steps);
        return base + 12'(steps);
    endfunction
    task automatic tick(input int cycles);
        repeat (cycles) @(negedge clk);
    endtask
    // hold the pin reset with a strap level, steps are requested throughout
    task automatic chip_rst(input logic sel);
        chip_reset_n <= 0;
        nmi_sel_n <= sel;
        pc_step <= 1;
        tick(6);
        chk(program_counter === 12'h000 && in_reset === 1'b1, "pc not held at zero");
        chip_reset_n <= 1;
        pc_step <= 0;
        for (int i = 0; i < 8 && in_reset !== 1'b0; i++) tick(1);
        chk(program_memory_select === sel, "memory select strap");
        chk(program_counter === 12'h000, "pc after reset");
        nmi_sel_n <= 1;
        tick(1);
    endtask
    // one transfer; a second request is made while busy and must be ignored
    task automatic xfer(input bit wr, input bit both, input logic [15:0] w);
        int lo;
        bit seen;
        lo = 0;
        seen = 0;
        wr_req <= wr;
        rd_req <= !wr || both;
        wr_data <= w;
        slow <= 1'($random(seed));
        for (int i = 0; i < 9; i++) begin
            tick(1);
            // requests settle by the third cycle; the next call drives them once
            if (i < 3) begin
                wr_req <= (i == 1) && !wr;
                rd_req <= (i == 1) && wr;
            end
            lo += int'(wr ? !write_strobe_n : !read_strobe_n);
            chk(bus_busy === (i < 4), "busy window");
            chk((wr ? read_strobe_n : write_strobe_n) === 1'b1, "other strobe active");
            chk(bus_data_oe === !write_strobe_n, "drive differs from strobe");
            if (bus_data_oe === 1'b1) chk(bus_data_out === w, "write data");
            if (rd_valid === 1'b1) begin
                seen = 1;
                chk(rd_data === w, "read data");
            end
        end
        chk(lo == 4 && seen == !wr && bus_busy === 1'b0, "strobe length or end");
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        tick(4);
        rst_n <= 1;
        chip_rst(1'b0);
        for (int k = 0; k < 12; k++) begin
            d = 16'($random(seed));
            if (k == 0) d = 16'hffff;
            xfer(1'b1, k == 3, d);
            xfer(1'b0, 1'b0, d);
        end
        // exact take latency, then a held low level must not fire again
        ext_irq_n <= 0;
        tick(3);
        chk(ext_irq_take === 1'b0, "interrupt early");
        tick(1);
        chk(ext_irq_take === 1'b1, "interrupt missing");
        ext_irq_ack <= 1;
        tick(1);
        ext_irq_ack <= 0;
        tick(10);
        chk(ext_irq_take === 1'b0, "level retriggered");
        ext_irq_n <= 1;
        global_irq_mask <= 1;
        tick(3);
        ext_irq_n <= 0;
        tick(8);
        chk(ext_irq_take === 1'b0, "masked interrupt taken");
        global_irq_mask <= 0;
        tick(1);
        chk(ext_irq_take === 1'b1, "pending lost under mask");
        ext_irq_ack <= 1;
        tick(1);
        ext_irq_ack <= 0;
        // the non-maskable one ignores the mask
        global_irq_mask <= 1;
        nmi_sel_n <= 0;
        tick(2);
        chk(nmi_take === 1'b0, "nmi early");
        tick(1);
        chk(nmi_take === 1'b1, "nmi blocked by mask");
        nmi_ack <= 1;
        tick(1);
        nmi_ack <= 0;
        tick(1);
        chk(nmi_take === 1'b0, "nmi not cleared");
        global_irq_mask <= 0;
        // load beats step in the same cycle, then count up
        v = 12'($random(seed));
        n = 1 + ($random(seed) & 15);
        pc_load_value <= v;
        pc_load <= 1;
        pc_step <= 1;
        tick(1);
        chk(program_counter === v, "pc load");
        pc_load <= 0;
        tick(n);
        pc_step <= 0;
        chk(program_counter === exp_pc(v, n), "pc count");
        chip_rst(1'b1);
        xfer(1'b1, 1'b0, 16'h0001);
        summarize();
    end
    // cut a hang short
    initial begin
        tick(20000);
        chk(1'b0, "timeout");
        summarize();
    end
endmodule // test_dsp_interrupt_reset_bus_strobes
